// ==== common/tcc_pkg.sv ====
// Package with register map, field layout and constants of the capture timer.
package tcc_pkg;

  // Register byte addresses on the AXI4-Lite slave.
  localparam logic [7:0] ADDR_COUNT_LOW   = 8'h00;
  localparam logic [7:0] ADDR_COUNT_HIGH  = 8'h04;
  localparam logic [7:0] ADDR_CAPT_LOW    = 8'h08;
  localparam logic [7:0] ADDR_CAPT_HIGH   = 8'h0C;
  localparam logic [7:0] ADDR_CTRL_A      = 8'h10;
  localparam logic [7:0] ADDR_CTRL_B      = 8'h14;
  localparam logic [7:0] ADDR_FLAGS       = 8'h18;
  localparam logic [7:0] ADDR_IRQ_EN      = 8'h1C;
  localparam logic [7:0] ADDR_CMP_CTRL    = 8'h20;
  localparam logic [7:0] ADDR_SERVICE     = 8'h24;

  // Field positions.
  localparam int CTRLB_TICK_LSB   = 0;
  localparam int CTRLB_WGM_HI_LSB = 3;
  localparam int CTRLB_EDGE_BIT   = 6;
  localparam int CTRLB_FILT_BIT   = 7;
  localparam int CTRLA_WGM_LO_LSB = 0;
  localparam int FLAG_OVF_BIT     = 0;
  localparam int FLAG_CAPT_BIT    = 5;
  localparam int CMP_SEL_BIT      = 2;

  // Counter extremes and constants.
  localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
  localparam logic [15:0] COUNT_MAX    = 16'hFFFF;
  localparam logic [2:0]  TICK_NONE    = 3'h0;
  localparam int          FILT_SAMPLES = 4;

  // Waveform modes that use the capture register as TOP.
  localparam logic [3:0] WGM_PWM_PFC_ICR = 4'h8;
  localparam logic [3:0] WGM_PWM_PC_ICR  = 4'hA;
  localparam logic [3:0] WGM_CTC_ICR     = 4'hC;
  localparam logic [3:0] WGM_FAST_ICR    = 4'hE;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Counter action requested by the mode logic.
  typedef enum logic [1:0] {
    TCC_ACT_HOLD = 2'b00,
    TCC_ACT_INC  = 2'b01,
    TCC_ACT_DEC  = 2'b10,
    TCC_ACT_CLR  = 2'b11
  } tcc_act_e;

  // Extreme-value indications of the counter.
  typedef struct packed {
    logic at_top;
    logic at_bottom;
  } tcc_ext_s;

endpackage : tcc_pkg

// ==== rtl/tcc_timer.sv ====
// Capture timer: 16-bit counter, shared high-byte latch, capture unit.
`timescale 1ns/1ps
module tcc_timer
  import tcc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        timer_tick,
  input  wire tcc_act_e    count_action,
  input  wire logic        overflow_event,
  input  wire logic        capture_pin,
  input  wire logic        comparator_output,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [15:0]      count_value,
  output logic [3:0]       waveform_mode_field,
  output logic [2:0]       tick_source_select,
  output tcc_ext_s         count_extremes,
  output logic             overflow_irq,
  output logic             capture_irq
);

  // Registers held by the block.
  logic [7:0]  high_latch;
  logic [15:0] capture_value;
  logic [7:0]  timer_control_a;
  logic [7:0]  timer_control_b;
  logic        overflow_flag;
  logic        capture_flag;
  logic        overflow_irq_enable;
  logic        capture_irq_enable;
  logic        comparator_capture_select;
  logic [1:0]  sync_pin;
  logic [1:0]  sync_cmp;
  logic [FILT_SAMPLES-2:0] filt_hist;
  logic        filt_out;
  logic        edge_prev;
  logic        edge_prev_valid;

  // Write channel holding registers: address and data taken in any order.
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [7:0]  w_data;
  logic        w_lane0;

  // Write channel acceptance.
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take  = s_axi_wvalid && s_axi_wready;
  wire wr_go   = aw_held && w_held;

  // Byte-lane zero carries the 8-bit register data.
  wire wr_en   = wr_go && w_lane0;
  wire wr_cl   = wr_en && (aw_addr == ADDR_COUNT_LOW);
  wire wr_hi   = wr_en && ((aw_addr == ADDR_COUNT_HIGH) ||
                           (aw_addr == ADDR_CAPT_HIGH));
  wire wr_capl = wr_en && (aw_addr == ADDR_CAPT_LOW);
  wire wr_ca   = wr_en && (aw_addr == ADDR_CTRL_A);
  wire wr_cb   = wr_en && (aw_addr == ADDR_CTRL_B);
  wire wr_fl   = wr_en && (aw_addr == ADDR_FLAGS);
  wire wr_ie   = wr_en && (aw_addr == ADDR_IRQ_EN);
  wire wr_cmp  = wr_en && (aw_addr == ADDR_CMP_CTRL);
  wire wr_svc  = wr_en && (aw_addr == ADDR_SERVICE);

  // Mode decode.
  wire [3:0] wgm_now = {timer_control_b[CTRLB_WGM_HI_LSB+1 -: 2],
                        timer_control_a[CTRLA_WGM_LO_LSB+1 -: 2]};
  wire icr_is_top = (wgm_now == WGM_PWM_PFC_ICR) ||
                    (wgm_now == WGM_PWM_PC_ICR) ||
                    (wgm_now == WGM_CTC_ICR) ||
                    (wgm_now == WGM_FAST_ICR);
  wire filt_en  = timer_control_b[CTRLB_FILT_BIT];
  wire edge_sel = timer_control_b[CTRLB_EDGE_BIT];
  wire [2:0] tick_sel = timer_control_b[CTRLB_TICK_LSB+2 -: 3];

  // Write mapping: unknown addresses get SLVERR.
  wire wr_known = (aw_addr == ADDR_COUNT_LOW) || (aw_addr == ADDR_COUNT_HIGH)
               || (aw_addr == ADDR_CAPT_LOW) || (aw_addr == ADDR_CAPT_HIGH)
               || (aw_addr == ADDR_CTRL_A) || (aw_addr == ADDR_CTRL_B)
               || (aw_addr == ADDR_FLAGS) || (aw_addr == ADDR_IRQ_EN)
               || (aw_addr == ADDR_CMP_CTRL) || (aw_addr == ADDR_SERVICE);

  // Write channel capture and response.
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 8'h00;
      w_lane0 <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: one read at a time, answer one cycle after address.
  assign s_axi_arready = !s_axi_rvalid;
  wire rd_take = s_axi_arvalid && s_axi_arready;
  wire rd_cl   = rd_take && (s_axi_araddr == ADDR_COUNT_LOW);
  wire rd_capl = rd_take && (s_axi_araddr == ADDR_CAPT_LOW);

  // Read data selection; high-byte locations return the latch.
  logic [7:0] rd_byte;
  logic       rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    if (s_axi_araddr == ADDR_COUNT_LOW) begin
      rd_byte = count_value[7:0];
    end else if (s_axi_araddr == ADDR_COUNT_HIGH) begin
      rd_byte = high_latch;
    end else if (s_axi_araddr == ADDR_CAPT_LOW) begin
      rd_byte = capture_value[7:0];
    end else if (s_axi_araddr == ADDR_CAPT_HIGH) begin
      rd_byte = high_latch;
    end else if (s_axi_araddr == ADDR_CTRL_A) begin
      rd_byte = timer_control_a;
    end else if (s_axi_araddr == ADDR_CTRL_B) begin
      rd_byte = timer_control_b;
    end else if (s_axi_araddr == ADDR_FLAGS) begin
      rd_byte = 8'h00;
      rd_byte[FLAG_OVF_BIT] = overflow_flag;
      rd_byte[FLAG_CAPT_BIT] = capture_flag;
    end else if (s_axi_araddr == ADDR_IRQ_EN) begin
      rd_byte = 8'h00;
      rd_byte[FLAG_OVF_BIT] = overflow_irq_enable;
      rd_byte[FLAG_CAPT_BIT] = capture_irq_enable;
    end else if (s_axi_araddr == ADDR_CMP_CTRL) begin
      rd_byte = 8'h00;
      rd_byte[CMP_SEL_BIT] = comparator_capture_select;
    end else if (s_axi_araddr == ADDR_SERVICE) begin
      rd_byte = 8'h00;
    end else begin
      rd_byte = 8'h00;
      rd_ok = 1'b0;
    end
  end

  // Read response register.
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_byte};
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Capture trigger path: synchronise, optionally filter, then detect edges.
  wire trig_sync = comparator_capture_select ? sync_cmp[1] : sync_pin[1];
  wire filt_all1 = &{filt_hist, trig_sync};
  wire filt_all0 = ~|{filt_hist, trig_sync};
  wire det_in    = filt_en ? filt_out : trig_sync;
  wire edge_hit  = !icr_is_top && edge_prev_valid && (det_in != edge_prev)
                   && (det_in == edge_sel);

  // Pin synchronisers and filter history.
  always_ff @(posedge clk) begin
    if (rst) begin
      sync_pin <= 2'b00;
      sync_cmp <= 2'b00;
      filt_hist <= '0;
      filt_out <= 1'b0;
    end else begin
      sync_pin <= {sync_pin[0], capture_pin};
      sync_cmp <= {sync_cmp[0], comparator_output};
      filt_hist <= {filt_hist[FILT_SAMPLES-3:0], trig_sync};
      // The last three stored samples plus the newest one must agree.
      if (filt_all1) begin
        filt_out <= 1'b1;
      end else if (filt_all0) begin
        filt_out <= 1'b0;
      end
    end
  end

  // Edge detector state; frozen while the capture value serves as top.
  always_ff @(posedge clk) begin
    if (rst) begin
      edge_prev <= 1'b0;
      edge_prev_valid <= 1'b0;
    end else if (!icr_is_top) begin
      edge_prev <= det_in;
      edge_prev_valid <= 1'b1;
    end
  end

  // Counter next value: software write first, then tick actions.
  wire tick_ok = timer_tick && (tick_sel != TICK_NONE);
  logic [15:0] next_count;
  always_comb begin
    next_count = count_value;
    if (wr_cl) begin
      next_count = {high_latch, w_data};
    end else if (tick_ok) begin
      case (count_action)
        TCC_ACT_INC:  next_count = count_value + 16'h0001;
        TCC_ACT_DEC:  next_count = count_value - 16'h0001;
        TCC_ACT_CLR:  next_count = COUNT_BOTTOM;
        default:      next_count = count_value;
      endcase
    end
  end

  // Counter and its extremes.
  always_ff @(posedge clk) begin
    if (rst) begin
      count_value <= COUNT_BOTTOM;
      count_extremes <= '{at_top: 1'b0, at_bottom: 1'b1};
    end else begin
      count_value <= next_count;
      count_extremes.at_top <= (next_count == COUNT_MAX);
      count_extremes.at_bottom <= (next_count == COUNT_BOTTOM);
    end
  end

  // Shared high-byte latch: written at high locations, loaded on low reads.
  always_ff @(posedge clk) begin
    if (rst) begin
      high_latch <= 8'h00;
    end else if (wr_hi) begin
      high_latch <= w_data;
    end else if (rd_cl) begin
      high_latch <= count_value[15:8];
    end else if (rd_capl) begin
      high_latch <= capture_value[15:8];
    end
  end

  // Capture value: hardware capture overwrites, software write only at top.
  always_ff @(posedge clk) begin
    if (rst) begin
      capture_value <= 16'h0000;
    end else if (edge_hit) begin
      capture_value <= count_value;
    end else if (wr_capl && icr_is_top) begin
      capture_value <= {high_latch, w_data};
    end
  end

  // Control registers.
  always_ff @(posedge clk) begin
    if (rst) begin
      timer_control_a <= 8'h00;
      timer_control_b <= 8'h00;
      overflow_irq_enable <= 1'b0;
      capture_irq_enable <= 1'b0;
      comparator_capture_select <= 1'b0;
    end else begin
      if (wr_ca) timer_control_a <= w_data;
      if (wr_cb) timer_control_b <= w_data;
      if (wr_ie) begin
        overflow_irq_enable <= w_data[FLAG_OVF_BIT];
        capture_irq_enable <= w_data[FLAG_CAPT_BIT];
      end
      if (wr_cmp) comparator_capture_select <= w_data[CMP_SEL_BIT];
    end
  end

  // Sticky flags: a set in the clearing cycle wins over the clear.
  wire clr_ovf  = (wr_fl || wr_svc) && w_data[FLAG_OVF_BIT];
  wire clr_capt = (wr_fl || wr_svc) && w_data[FLAG_CAPT_BIT];
  always_ff @(posedge clk) begin
    if (rst) begin
      overflow_flag <= 1'b0;
      capture_flag <= 1'b0;
    end else begin
      if (overflow_event) overflow_flag <= 1'b1;
      else if (clr_ovf) overflow_flag <= 1'b0;
      if (edge_hit) capture_flag <= 1'b1;
      else if (clr_capt) capture_flag <= 1'b0;
    end
  end

  // Interrupt request, waveform mode and tick source outputs, registered.
  always_ff @(posedge clk) begin
    if (rst) begin
      overflow_irq <= 1'b0;
      capture_irq <= 1'b0;
      waveform_mode_field <= 4'h0;
      tick_source_select <= TICK_NONE;
    end else begin
      overflow_irq <= overflow_flag && overflow_irq_enable;
      capture_irq <= capture_flag && capture_irq_enable;
      waveform_mode_field <= wgm_now;
      tick_source_select <= tick_sel;
    end
  end

  // Assertions.
  a_capture_copies: assert property (@(posedge clk) disable iff (rst)
    edge_hit |=> capture_value == $past(count_value))
    else $error("capture value not copied");
  a_flag_with_capt: assert property (@(posedge clk) disable iff (rst)
    edge_hit |=> capture_flag)
    else $error("capture flag not set with capture");
  a_write_priority: assert property (@(posedge clk) disable iff (rst)
    wr_cl |=> count_value == {$past(high_latch), $past(w_data)})
    else $error("counter write lost");
  a_stopped_count: assert property (@(posedge clk) disable iff (rst)
    (tick_sel == TICK_NONE) && !wr_cl |=> $stable(count_value))
    else $error("counter moved while stopped");
  a_low_read_latch: assert property (@(posedge clk) disable iff (rst)
    rd_cl && !wr_hi |=> high_latch == $past(count_value[15:8]))
    else $error("latch not loaded on low read");
  a_latch_holds: assert property (@(posedge clk) disable iff (rst)
    !wr_hi && !rd_cl && !rd_capl |=> $stable(high_latch))
    else $error("latch changed without cause");
  sequence s_agree4;
    trig_sync [*4];
  endsequence
  a_filter_agree: assert property (@(posedge clk) disable iff (rst)
    $rose(filt_out) |-> $past(filt_all1))
    else $error("filter changed without agreement");
  a_filter_rises: assert property (@(posedge clk) disable iff (rst)
    s_agree4 |=> filt_out)
    else $error("filter did not follow input");
  a_no_capt_top: assert property (@(posedge clk) disable iff (rst)
    icr_is_top && !wr_capl |=> $stable(capture_value))
    else $error("capture while capture is top");
  a_capt_irq: assert property (@(posedge clk) disable iff (rst)
    capture_flag && capture_irq_enable |=> capture_irq)
    else $error("capture irq missing");

endmodule : tcc_timer

// ==== verif/tcc_event_src.sv ====
// Partner model: the outside event source feeding the capture inputs.
`timescale 1ns/1ps
module tcc_event_src (
  input  wire logic clk,
  output logic      capture_pin,
  output logic      comparator_output
);
  // Both lines are driven levels, so they always show a defined value.
  initial begin
    capture_pin       = 1'b0;
    comparator_output = 1'b0;
  end

  // Changes land just after a clock edge, like a port pin written by code.
  task automatic set_pin(input logic v);
    @(posedge clk);
    capture_pin <= v;
  endtask : set_pin

  task automatic set_cmp(input logic v);
    @(posedge clk);
    comparator_output <= v;
  endtask : set_cmp

  // A short pulse that a working filter must swallow.
  task automatic glitch(input int n);
    set_pin(1'b1);
    repeat (n) @(posedge clk);
    capture_pin <= 1'b0;
  endtask : glitch
endmodule : tcc_event_src

// ==== verif/tcc_timer_tb_top.sv ====
// Self-checking testbench of the capture timer.
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tcc_timer_tb_top
  import tcc_pkg::*;
;
  logic clk, rst, timer_tick, overflow_event, awvalid, wvalid, bready;
  logic arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic capture_pin, comparator_output, overflow_irq, capture_irq;
  logic [7:0] awaddr, araddr;
  logic [3:0] wstrb;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rs, bs;
  logic [15:0] count_value;
  logic [3:0] waveform_mode_field;
  logic [2:0] tick_source_select;
  tcc_ext_s count_extremes;
  tcc_act_e count_action;
  int err_total, cmp_count, c0, c1;

  tcc_timer tcc_timer_inst (.clk(clk), .rst(rst), .timer_tick(timer_tick),
    .count_action(count_action), .overflow_event(overflow_event),
    .capture_pin(capture_pin), .comparator_output(comparator_output),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .count_value(count_value), .waveform_mode_field(waveform_mode_field),
    .tick_source_select(tick_source_select),
    .count_extremes(count_extremes), .overflow_irq(overflow_irq),
    .capture_irq(capture_irq));

  tcc_event_src tcc_event_src_inst (.clk(clk), .capture_pin(capture_pin),
    .comparator_output(comparator_output));

  // Free-running 20 MHz system clock.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  // Write cycle: address and data offered together, each dropped when taken.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bs = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask : wr

  // Read cycle: data and response are taken at the edge that sees rvalid.
  task automatic rdr(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask : rdr

  task automatic tick(input tcc_act_e act);
    count_action <= act;
    timer_tick <= 1'b1;
    @(posedge clk);
    timer_tick <= 1'b0;
    wt(2);
  endtask : tick

  // Pin change to capture interrupt, counted in system clock cycles.
  task automatic lat(input logic v, output int c);
    tcc_event_src_inst.set_pin(v);
    c = 0;
    while (capture_irq !== 1'b1 && c < 40) begin
      @(posedge clk);
      c++;
    end
  endtask : lat

  task automatic clr_capt();
    wt(12);
    wr(ADDR_FLAGS, 8'h20);
    wt(3);
  endtask : clr_capt

  task automatic t_counter();
    `CHK(count_extremes.at_bottom, 1'b1)
    wr(ADDR_COUNT_HIGH, 8'h12);
    `CHK(count_value, 16'h0000)
    wr(ADDR_COUNT_LOW, 8'h34);
    `CHK(count_value, 16'h1234)
    `CHK(bs, RESP_OKAY)
    wstrb <= 4'h0;
    wr(ADDR_COUNT_LOW, 8'h99);
    wstrb <= 4'h1;
    `CHK(count_value, 16'h1234)
    wr(ADDR_COUNT_HIGH, 8'h55);
    rdr(ADDR_COUNT_LOW);
    `CHK(rd, 32'h0000_0034)
    rdr(ADDR_COUNT_HIGH);
    `CHK(rd, 32'h0000_0012)
    wr(ADDR_COUNT_HIGH, 8'hFF);
    wr(ADDR_COUNT_LOW, 8'hFF);
    `CHK(count_extremes.at_top, 1'b1)
    rdr(8'h30);
    `CHK({rs, rd}, {RESP_SLVERR, 32'h0000_0000})
    wr(8'h30, 8'h00);
    `CHK(bs, RESP_SLVERR)
  endtask : t_counter

  task automatic t_ticks();
    wr(ADDR_COUNT_HIGH, 8'h00);
    wr(ADDR_COUNT_LOW, 8'h10);
    tick(TCC_ACT_INC);
    `CHK(count_value, 16'h0010)
    wr(ADDR_CTRL_B, 8'h01);
    `CHK(tick_source_select, 3'h1)
    tick(TCC_ACT_INC);
    tick(TCC_ACT_INC);
    `CHK(count_value, 16'h0012)
    tick(TCC_ACT_DEC);
    `CHK(count_value, 16'h0011)
    tick(TCC_ACT_CLR);
    `CHK(count_value, 16'h0000)
    tick(TCC_ACT_HOLD);
    `CHK(count_value, 16'h0000)
    // Ticks stay high across the low-byte write, which must still land.
    count_action <= TCC_ACT_DEC;
    timer_tick <= 1'b1;
    wr(ADDR_COUNT_LOW, 8'h40);
    timer_tick <= 1'b0;
    wt(1);
    `CHK(count_value, 16'h003E)
    wr(ADDR_CTRL_B, 8'h00);
    wr(ADDR_IRQ_EN, 8'h21);
    overflow_event <= 1'b1;
    @(posedge clk);
    overflow_event <= 1'b0;
    wt(3);
    `CHK(overflow_irq, 1'b1)
    wr(ADDR_FLAGS, 8'h01);
    wt(2);
    `CHK(overflow_irq, 1'b0)
  endtask : t_ticks

  task automatic t_capture();
    wr(ADDR_COUNT_HIGH, 8'h01);
    wr(ADDR_COUNT_LOW, 8'h00);
    wr(ADDR_CTRL_B, 8'h40);
    clr_capt();
    lat(1'b1, c0);
    rdr(ADDR_FLAGS);
    `CHK(rd[FLAG_CAPT_BIT], 1'b1)
    rdr(ADDR_CAPT_LOW);
    `CHK(rd, 32'h0000_0000)
    rdr(ADDR_CAPT_HIGH);
    `CHK(rd, 32'h0000_0001)
    wr(ADDR_COUNT_HIGH, 8'h02);
    wr(ADDR_COUNT_LOW, 8'h03);
    wr(ADDR_CTRL_B, 8'h00);
    wr(ADDR_SERVICE, 8'h20);
    wt(2);
    `CHK(capture_irq, 1'b0)
    lat(1'b0, c1);
    rdr(ADDR_CAPT_LOW);
    `CHK(rd, 32'h0000_0003)
    wr(ADDR_CAPT_LOW, 8'h77);
    rdr(ADDR_CAPT_LOW);
    `CHK(rd, 32'h0000_0003)
    wr(ADDR_CMP_CTRL, 8'h04);
    wr(ADDR_CTRL_B, 8'h40);
    clr_capt();
    tcc_event_src_inst.set_pin(1'b1);
    wt(15);
    `CHK(capture_irq, 1'b0)
    tcc_event_src_inst.set_cmp(1'b1);
    wt(15);
    `CHK(capture_irq, 1'b1)
  endtask : t_capture

  task automatic t_filter();
    wr(ADDR_CMP_CTRL, 8'h00);
    tcc_event_src_inst.set_pin(1'b0);
    clr_capt();
    lat(1'b1, c0);
    tcc_event_src_inst.set_pin(1'b0);
    wr(ADDR_CTRL_B, 8'hC0);
    clr_capt();
    tcc_event_src_inst.glitch(3);
    wt(20);
    `CHK(capture_irq, 1'b0)
    lat(1'b1, c1);
    `CHK(c1 - c0, FILT_SAMPLES)
    `CHK(c1 < 40, 1'b1)
  endtask : t_filter

  task automatic t_icr_top();
    tcc_event_src_inst.set_pin(1'b0);
    wr(ADDR_CTRL_B, 8'h58);
    `CHK(waveform_mode_field, WGM_CTC_ICR)
    clr_capt();
    tcc_event_src_inst.set_pin(1'b1);
    wt(20);
    `CHK(capture_irq, 1'b0)
    wr(ADDR_CAPT_HIGH, 8'hAB);
    wr(ADDR_CAPT_LOW, 8'h02);
    rdr(ADDR_CAPT_LOW);
    `CHK(rd, 32'h0000_0002)
    rdr(ADDR_CAPT_HIGH);
    `CHK(rd, 32'h0000_00AB)
    wr(ADDR_COUNT_LOW, 8'h07);
    `CHK(count_value, 16'hAB07)
    wr(ADDR_CTRL_A, 8'h02);
    `CHK(waveform_mode_field, WGM_FAST_ICR)
  endtask : t_icr_top

  task automatic conclude();
    $display("mismatches %0d comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude

  // Main sequence: reset for eight cycles, then one task per scenario.
  initial begin
    {rst, timer_tick, overflow_event} = 3'b100;
    {awvalid, wvalid, bready, arvalid, rready} = 5'b0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'h1;
    count_action = TCC_ACT_HOLD;
    err_total = 0;
    cmp_count = 0;
    wt(8);
    rst <= 1'b0;
    wt(2);
    t_counter();
    t_ticks();
    t_capture();
    t_filter();
    t_icr_top();
    conclude();
  end

  // Watchdog: the scenarios need a few thousand cycles at most.
  initial begin
    wt(20000);
    err_total++;
    conclude();
  end
endmodule : tcc_timer_tb_top
